//--- src/host_port_16bit_mux_access.sv
`timescale 1ns/10ps
`include "host_port_defines.svh"
module host_port_16bit_mux_access
  import host_port_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  addr_strobe_n,
  input  wire logic                  data_strobe_a_n,
  input  wire logic                  data_strobe_b_n,
  input  wire logic                  port_select_n,
  input  wire logic                  read_not_write,
  input  wire logic                  access_ctl_low,
  input  wire logic                  access_ctl_high,
  input  wire logic [`HP_ADDR_W-1:0] host_addr_in, // R9
  input  wire logic [`HP_DATA_W-1:0] host_data_in,
  output logic      [`HP_DATA_W-1:0] host_data_out,
  output logic                       host_data_oe,
  output logic                       host_ready_out,
  output logic                       host_ready_oe,
  output logic                       host_irq_out,
  output logic                       host_irq_oe,
  input  wire logic                  port_reset_in,
  input  wire logic                  port_enable_in,
  input  wire logic                  width_select_in,
  input  wire logic                  mux_mode_select,
  input  wire logic                  emulation_off_n,
  input  wire logic                  dsp_host_irq_out_set,
  output logic                       dsp_int_pulse,
  output logic      [`HP_DATA_W-1:0] port_control_out,
  output logic                       mem_req,
  output logic                       mem_we,
  output logic      [`HP_ADDR_W-1:0] mem_addr,
  output logic      [`HP_DATA_W-1:0] mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [`HP_DATA_W-1:0] mem_rdata
);
  localparam int SW = 12 + `HP_DATA_W + `HP_ADDR_W;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [SW-1:0] pins_s;
  logic          has_n_s;
  logic          dsa_s;
  logic          dsb_s;
  logic          cs_n_s;
  logic          rnw_s;
  logic [1:0]    ctl_s;
  logic          emu_n_s;
  logic          prst_s;
  logic          pena_s;
  logic          wsel_s;
  logic          mode_s;
  word_t         hdata_s;
  addr_t         haddr_s;

  host_port_sync #(.W(SW)) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .d_in    ({addr_strobe_n, data_strobe_a_n, data_strobe_b_n, port_select_n,
               read_not_write, access_ctl_high, access_ctl_low, emulation_off_n,
               port_reset_in, port_enable_in, width_select_in, mux_mode_select,
               host_data_in, host_addr_in}),
    .d_out   (pins_s)
  );

  assign {has_n_s, dsa_s, dsb_s, cs_n_s, rnw_s, ctl_s, emu_n_s, prst_s, pena_s,
          wsel_s, mode_s, hdata_s, haddr_s} = pins_s;

  //////////////////////////////////////////////////////////////////////////////
  // Strobe decode
  logic strobe_s;
  logic live;
  logic stb_d_r;
  logic has_d_r;
  logic stb_fall;
  logic stb_rise;
  logic has_fall;

  // Internal strobe needs select low and exactly one data strobe low
  assign strobe_s = ~cs_n_s & (dsa_s ^ dsb_s); // R25
  // Port answers only when enabled, out of reset and in 16-bit mode
  assign live     = pena_s & ~prst_s & wsel_s; // R20 R21 R22
  assign stb_fall = live & strobe_s & ~stb_d_r;
  assign stb_rise = live & ~strobe_s & stb_d_r;
  assign has_fall = live & ~mode_s & ~has_n_s & has_d_r; // R23

  // Edge history
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stb_d_r <= 1'b0;
      has_d_r <= 1'b1;
    end else begin
      stb_d_r <= strobe_s;
      has_d_r <= has_n_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port state
  port_state_e state_r, state_nxt;
  logic [1:0]  ctl_r, ctl_nxt;
  logic        rnw_r, rnw_nxt;
  logic        as_seen_r, as_seen_nxt;
  addr_t       addr_r, addr_nxt;
  word_t       data_r, data_nxt;
  word_t       dout_r, dout_nxt;
  logic        host_irq_out_r, host_irq_out_nxt;
  logic        xaddr_r, xaddr_nxt;
  logic        busy_r, busy_nxt;
  logic        inc_r, inc_nxt;
  logic        req_r, req_nxt;
  logic        we_r, we_nxt;
  logic        dspint_r, dspint_nxt;
  word_t       ctl_word;

  // Control register image, ready bit mirrors the pin
  always_comb begin
    ctl_word = `HP_DATA_RST;
    ctl_word[`HP_BIT_HOST_IRQ_OUT]  = host_irq_out_r;
    ctl_word[`HP_BIT_READY] = host_ready_out; // R15
    ctl_word[`HP_BIT_XADDR] = xaddr_r;
  end

  // Next-state logic for the access sequencer
  always_comb begin
    state_nxt   = state_r;
    ctl_nxt     = ctl_r;
    rnw_nxt     = rnw_r;
    as_seen_nxt = as_seen_r;
    addr_nxt    = addr_r;
    data_nxt    = data_r;
    dout_nxt    = dout_r;
    host_irq_out_nxt    = host_irq_out_r;
    xaddr_nxt   = xaddr_r;
    busy_nxt    = busy_r;
    inc_nxt     = inc_r;
    req_nxt     = req_r;
    we_nxt      = we_r;
    dspint_nxt  = 1'b0;

    // Shared-bus host: controls taken at address strobe
    if (has_fall) begin
      ctl_nxt     = ctl_s; // R7
      rnw_nxt     = rnw_s;
      as_seen_nxt = 1'b1;
    end

    // Controls taken at data strobe when no address strobe came
    if (stb_fall) begin
      if (mode_s) begin
        ctl_nxt  = `HP_ACC_DATA;
        rnw_nxt  = rnw_s;
        addr_nxt = haddr_s;
      end else if (!as_seen_r) begin
        ctl_nxt = ctl_s; // R1 R6
        rnw_nxt = rnw_s;
      end
    end

    if (stb_fall && state_r == ST_IDLE && rnw_nxt) begin // R24
      case (ctl_nxt)
        `HP_ACC_CTRL: dout_nxt = ctl_word; // R2
        `HP_ACC_ADDR: begin
          // Upper address bits appear when extended mode is set
          dout_nxt = xaddr_r ? {{(`HP_DATA_W-`HP_HIGH_W){1'b0}},
                                addr_r[`HP_ADDR_W-1:`HP_DATA_W]}
                             : addr_r[`HP_DATA_W-1:0]; // R4
        end
        default: begin
          state_nxt = ST_MEM;
          busy_nxt  = 1'b1;
          req_nxt   = 1'b1;
          we_nxt    = 1'b0;
          inc_nxt   = (ctl_nxt == `HP_ACC_DINC); // R3 R5
        end
      endcase
    end

    if (stb_rise) begin
      as_seen_nxt = 1'b0;
      if (state_r == ST_IDLE && !rnw_r) begin
        case (ctl_r)
          `HP_ACC_CTRL: begin
            if (hdata_s[`HP_BIT_HOST_IRQ_OUT]) begin
              host_irq_out_nxt = 1'b0; // R18
            end
            dspint_nxt = hdata_s[`HP_BIT_DSPINT];
            xaddr_nxt  = hdata_s[`HP_BIT_XADDR];
            // Fetch request loads the data register from memory
            if (hdata_s[`HP_BIT_FETCH]) begin
              state_nxt = ST_MEM;
              busy_nxt  = 1'b1;
              req_nxt   = 1'b1;
              we_nxt    = 1'b0;
              inc_nxt   = 1'b0;
            end
          end
          `HP_ACC_ADDR: begin
            if (xaddr_r) begin
              addr_nxt[`HP_ADDR_W-1:`HP_DATA_W] = hdata_s[`HP_HIGH_W-1:0];
            end else begin
              addr_nxt[`HP_DATA_W-1:0] = hdata_s; // R4
            end
          end
          default: begin
            data_nxt  = hdata_s; // R26
            state_nxt = ST_MEM;
            busy_nxt  = 1'b1;
            req_nxt   = 1'b1;
            we_nxt    = 1'b1;
            inc_nxt   = (ctl_r == `HP_ACC_DINC); // R3 R5
          end
        endcase
      end
    end

    // Memory transfer completes, then the address may step
    if (state_r == ST_MEM && mem_ack) begin
      if (!we_r) begin
        data_nxt = mem_rdata;
        dout_nxt = mem_rdata;
      end
      if (inc_r) begin
        addr_nxt = addr_r + 1'b1; // R27 R3
      end
      state_nxt = ST_IDLE;
      busy_nxt  = 1'b0; // R12
      req_nxt   = 1'b0;
      inc_nxt   = 1'b0;
    end

    // Set from the DSP wins over a host clear
    if (dsp_host_irq_out_set) begin
      host_irq_out_nxt = 1'b1; // R17
    end

    // Port off or in reset: drop any access in flight
    if (!live) begin
      state_nxt   = ST_IDLE;
      busy_nxt    = 1'b0;
      req_nxt     = 1'b0;
      inc_nxt     = 1'b0;
      as_seen_nxt = 1'b0;
      dspint_nxt  = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= ST_IDLE;
      ctl_r     <= `HP_ACC_CTRL;
      rnw_r     <= 1'b0;
      as_seen_r <= 1'b0;
      addr_r    <= `HP_ADDR_RST;
      data_r    <= `HP_DATA_RST;
      dout_r    <= `HP_DATA_RST;
      host_irq_out_r    <= 1'b0;
      xaddr_r   <= 1'b0;
      busy_r    <= 1'b0;
      inc_r     <= 1'b0;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      dspint_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ctl_r     <= ctl_nxt;
      rnw_r     <= rnw_nxt;
      as_seen_r <= as_seen_nxt;
      addr_r    <= addr_nxt;
      data_r    <= data_nxt;
      dout_r    <= dout_nxt;
      host_irq_out_r    <= host_irq_out_nxt;
      xaddr_r   <= xaddr_nxt;
      busy_r    <= busy_nxt;
      inc_r     <= inc_nxt;
      req_r     <= req_nxt;
      we_r      <= we_nxt;
      dspint_r  <= dspint_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and DSP-side outputs
  assign host_data_out    = dout_r;
  // Bus driven only during a read strobe with the data ready
  assign host_data_oe     = live & emu_n_s & strobe_s & rnw_r & ~busy_r; // R11 R20
  assign host_ready_out   = cs_n_s | ~busy_r; // R12 R14
  assign host_ready_oe    = emu_n_s & live; // R16 R21
  assign host_irq_out     = ~host_irq_out_r; // R19
  assign host_irq_oe      = emu_n_s & pena_s; // R16
  assign dsp_int_pulse    = dspint_r;
  assign port_control_out = ctl_word;
  assign mem_req          = req_r;
  assign mem_we           = we_r;
  assign mem_addr         = addr_r;
  assign mem_wdata        = data_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ready_cs;
    @(posedge clk_sys) disable iff (!arst_n) cs_n_s |-> host_ready_out;
  endproperty
  a_ready_cs: assert property (p_ready_cs) else $error("ready low while deselected"); // R14

  property p_ready_busy;
    @(posedge clk_sys) disable iff (!arst_n)
      (state_r == ST_MEM && !cs_n_s) |-> !host_ready_out && !port_control_out[`HP_BIT_READY];
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready high during transfer"); // R12

  property p_emu_float;
    @(posedge clk_sys) disable iff (!arst_n)
      !emu_n_s |-> !host_ready_oe && !host_irq_oe && !host_data_oe;
  endproperty
  a_emu_float: assert property (p_emu_float) else $error("driving under emulation-off"); // R16

  property p_irq_set;
    @(posedge clk_sys) disable iff (!arst_n) dsp_host_irq_out_set |=> !host_irq_out;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised"); // R17

  property p_prst_float;
    @(posedge clk_sys) disable iff (!arst_n)
      prst_s |-> !host_data_oe ##1 (state_r == ST_IDLE);
  endproperty
  a_prst_float: assert property (p_prst_float) else $error("port reset not honoured"); // R20

  property p_autoinc;
    @(posedge clk_sys) disable iff (!arst_n)
      (state_r == ST_MEM && mem_ack && inc_r && live) |=> (addr_r == $past(addr_r) + 1'b1);
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("address did not step"); // R3

  property p_noinc;
    @(posedge clk_sys) disable iff (!arst_n)
      (state_r == ST_MEM && mem_ack && !inc_r && !stb_fall) |=> $stable(addr_r);
  endproperty
  a_noinc: assert property (p_noinc) else $error("address moved on plain access"); // R5

  property p_wr_capture;
    @(posedge clk_sys) disable iff (!arst_n)
      (stb_rise && state_r == ST_IDLE && !rnw_r && ctl_r[0])
        |=> (data_r == $past(hdata_s)) ##[1:1000] (state_r == ST_IDLE);
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("write data not captured"); // R26

  property p_oe_read;
    @(posedge clk_sys) disable iff (!arst_n) host_data_oe |-> rnw_r && !cs_n_s;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("bus driven outside a read"); // R11

  property p_off;
    @(posedge clk_sys) disable iff (!arst_n) !pena_s |-> !host_ready_oe ##1 !mem_req;
  endproperty
  a_off: assert property (p_off) else $error("port active while disabled"); // R21

  property p_cv_inc_read;
    @(posedge clk_sys) disable iff (!arst_n) state_r == ST_MEM && inc_r && !we_r && mem_ack;
  endproperty
  c_inc_read: cover property (p_cv_inc_read);

  property p_cv_write;
    @(posedge clk_sys) disable iff (!arst_n) state_r == ST_MEM && we_r && mem_ack;
  endproperty
  c_write: cover property (p_cv_write);

  property p_cv_as;
    @(posedge clk_sys) disable iff (!arst_n) has_fall ##[1:20] stb_fall;
  endproperty
  c_as: cover property (p_cv_as);
endmodule

//--- src/host_port_defines.svh
// What this block does
// R1: Latch access controls on strobe falling edge
// R2: Control pair 00 selects control register
// R3: Pair 01 accesses data, address post-increments
// R4: Pair 10 accesses the address register
// R5: Pair 11 accesses data, address unchanged
// R6: Dedicated-line host: controls captured at data strobe
// R7: Shared-bus host: controls captured at address strobe
// R8: Host loads address once, then auto-increments
// R9: Host address width is top index plus one
// R10: Shared-bus host may tie address inputs
// R11: Drive data bus only during reads, emulation on
// R12: Ready high when done, low when busy
// R13: Host waits for ready high before next access
// R14: Ready forced high while chip select high
// R15: Ready level readable in control register
// R16: Ready and interrupt float under emulation-off
// R17: DSP writing one raises host interrupt
// R18: Host clears interrupt by writing one
// R19: Interrupt pin is inverse bit, high in reset
// R20: Port reset refuses accesses, floats data bus
// R21: Enable low switches whole port off
// R22: Width select one means sixteen-bit host
// R23: Mode select low means multiplexed operation
// R24: Direction one reads port, zero writes
// R25: Strobes ignored while chip select high; the address strobe is not gated and still latches controls
// R26: Data write captured on strobe rising edge
// R27: Increment once after memory transfer completes
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// Widths
`define HP_DATA_W      16
`define HP_ADDR_W      18
`define HP_HIGH_W      2

// Access-control codes {high, low}
`define HP_ACC_CTRL    2'h0
`define HP_ACC_DINC    2'h1
`define HP_ACC_ADDR    2'h2
`define HP_ACC_DATA    2'h3

// Control register field positions
`define HP_BIT_DSPINT  1
`define HP_BIT_HOST_IRQ_OUT    2
`define HP_BIT_READY   3
`define HP_BIT_FETCH   4
`define HP_BIT_XADDR   5

// Reset values
`define HP_ADDR_RST    18'h00000
`define HP_DATA_RST    16'h0000

`endif

//--- src/host_port_pkg.sv
package host_port_pkg;
  `include "host_port_defines.svh"

  typedef logic [`HP_DATA_W-1:0] word_t;
  typedef logic [`HP_ADDR_W-1:0] addr_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM
  } port_state_e;
endpackage

//--- src/host_port_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a bundle of pin levels
module host_port_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign d_out = sync_r;
endmodule

//--- verification/host_cpu_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Host processor on the far side of the parallel port
module host_cpu_model
  import host_port_pkg::*;
(
  input  wire logic  clk_sys,
  output logic       addr_strobe_n,
  output logic       data_strobe_a_n,
  output logic       data_strobe_b_n,
  output logic       port_select_n,
  output logic       read_not_write,
  output logic       access_ctl_low,
  output logic       access_ctl_high,
  output word_t      host_data_in,
  input  wire word_t host_data_out,
  input  wire logic  host_data_oe,
  input  wire logic  host_ready_out,
  input  wire logic  host_ready_oe
);
  word_t drv;
  logic  drv_en;
  word_t idle_pat;

  // Bus level: port, host, or a pattern that moves every cycle when released
  assign host_data_in = host_data_oe ? host_data_out : (drv_en ? drv : idle_pat);

  // Idle levels, select held low between accesses
  initial begin
    {addr_strobe_n, data_strobe_a_n, data_strobe_b_n} = 3'h7;
    {port_select_n, read_not_write, access_ctl_low, access_ctl_high} = 4'h0;
    drv_en   = 1'b0;
    drv      = 16'h0000;
    idle_pat = 16'h5a5a;
  end

  always @(posedge clk_sys) begin
    idle_pat <= ~idle_pat;
  end

  // Bounded wait for ready, sampled mid-cycle; a floating ready reads high by pull-up
  task automatic wait_ready();
    for (int n = 0; n < 300; n++) begin
      @(negedge clk_sys);
      if (host_ready_oe !== 1'b1 || host_ready_out === 1'b1) break;
    end
  endtask

  // One host access; read strobe on b, write strobe on a
  task automatic access(input logic [1:0] ctl, input logic rnw, input word_t wd,
                        input logic use_as, input logic cs_n, output word_t rd);
    @(posedge clk_sys);
    port_select_n   <= cs_n;
    access_ctl_high <= ctl[1];
    access_ctl_low  <= ctl[0];
    read_not_write  <= rnw;
    if (use_as) begin
      addr_strobe_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      addr_strobe_n   <= 1'b1;
      access_ctl_high <= ~ctl[1]; // Shared bus now carries other bits
      access_ctl_low  <= ~ctl[0];
      read_not_write  <= ~rnw;
      repeat (4) @(posedge clk_sys);
    end
    drv    <= wd;
    drv_en <= ~rnw;
    if (rnw) data_strobe_b_n <= 1'b0;
    else data_strobe_a_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wait_ready();
    rd = host_data_in;
    @(posedge clk_sys);
    data_strobe_a_n <= 1'b1;
    data_strobe_b_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wait_ready();
    @(posedge clk_sys);
    drv_en        <= 1'b0;
    port_select_n <= 1'b0;
  endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/10ps
`include "host_port_defines.svh"
// Compare one observed value with its expected value
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin fail_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (act), (exp)); end end
////////////////////////////////////////////////////////////////////////////////
module tb
  import host_port_pkg::*;
();
  logic  clk_sys, arst_n, addr_strobe_n, data_strobe_a_n, data_strobe_b_n, port_select_n;
  logic  read_not_write, access_ctl_low, access_ctl_high, host_data_oe, host_ready_out;
  logic  host_ready_oe, host_irq_out, host_irq_oe, port_reset_in, port_enable_in;
  logic  width_select_in, mux_mode_select, emulation_off_n, dsp_host_irq_out_set, dsp_int_pulse;
  logic  mem_req, mem_we, mem_ack;
  addr_t host_addr_in, mem_addr;
  word_t host_data_in, host_data_out, port_control_out, mem_wdata, mem_rdata, rd;
  word_t mem [16];
  int    fail_count, checks, busy_cnt, oe_cnt, dspint_cnt, rdy_bad, mem_wait, oe0, b0;

  host_port_16bit_mux_access uut (
    .clk_sys, .arst_n, .addr_strobe_n, .data_strobe_a_n, .data_strobe_b_n, .port_select_n,
    .read_not_write, .access_ctl_low, .access_ctl_high, .host_addr_in, .host_data_in,
    .host_data_out, .host_data_oe, .host_ready_out, .host_ready_oe, .host_irq_out,
    .host_irq_oe, .port_reset_in, .port_enable_in, .width_select_in, .mux_mode_select,
    .emulation_off_n, .dsp_host_irq_out_set, .dsp_int_pulse, .port_control_out, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  host_cpu_model host (
    .clk_sys, .addr_strobe_n, .data_strobe_a_n, .data_strobe_b_n, .port_select_n,
    .read_not_write, .access_ctl_low, .access_ctl_high, .host_data_in, .host_data_out,
    .host_data_oe, .host_ready_out, .host_ready_oe);

  always #5 clk_sys = ~clk_sys;

  // Memory behind the port: odd addresses answer slowly, stale data is inverted
  always @(posedge clk_sys) begin
    if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req === 1'b1 && mem_wait < 5 * mem_addr[0]) begin
      mem_wait <= mem_wait + 1;
    end else if (mem_req === 1'b1) begin
      mem_wait <= 0;
      mem_ack  <= 1'b1;
      if (mem_we) mem[mem_addr[3:0]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[3:0]];
    end
  end

  // Watch busy cycles, bus drives, DSP pulses and the ready status bit
  always @(negedge clk_sys) begin
    if (host_ready_out === 1'b0) busy_cnt++;
    if (host_data_oe === 1'b1) oe_cnt++;
    if (dsp_int_pulse === 1'b1) dspint_cnt++;
    if (host_ready_oe === 1'b1 && port_control_out[`HP_BIT_READY] !== host_ready_out) rdy_bad++;
  end

  task automatic wr(input logic [1:0] c, input word_t d, input logic use_as = 1'b0,
                    input logic cs_n = 1'b0);
    word_t x;
    host.access(c, 1'b0, d, use_as, cs_n, x);
  endtask

  task automatic rdh(input logic [1:0] c, output word_t d);
    host.access(c, 1'b1, 16'h0000, 1'b0, 1'b0, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100us;
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {clk_sys, arst_n, port_reset_in, mux_mode_select, dsp_host_irq_out_set, mem_ack} = 6'h00;
    {port_enable_in, width_select_in, emulation_off_n} = 3'h7;
    host_addr_in = 18'h00000;
    mem_rdata    = 16'h0000;
    repeat (16) @(posedge clk_sys);
    idle(1);
    `CHK(host_irq_out, 1'b1)
    `CHK(host_data_oe, 1'b0)
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Address register, then auto-increment writes
    wr(2'h2, 16'h0004);
    rdh(2'h2, rd);
    `CHK(rd, 16'h0004)
    b0 = busy_cnt;
    for (int i = 0; i < 3; i++) wr(2'h1, 16'ha001 + i);
    for (int i = 0; i < 3; i++) `CHK(mem[4 + i], 16'ha001 + i)
    `CHK(busy_cnt > b0, 1'b1)
    rdh(2'h2, rd);
    `CHK(rd, 16'h0007)
    wr(2'h3, 16'hbeef);
    `CHK(mem[7], 16'hbeef)
    rdh(2'h3, rd);
    `CHK(rd, 16'hbeef)
    rdh(2'h2, rd);
    `CHK(rd, 16'h0007)
    // Controls latched at the address strobe, then changed on the shared bus
    wr(2'h2, 16'h0004, 1'b1);
    rdh(2'h1, rd);
    `CHK(rd, 16'ha001)
    rdh(2'h1, rd);
    `CHK(rd, 16'ha002)
    rdh(2'h2, rd);
    `CHK(rd, 16'h0006)
    `CHK(rdy_bad, 0)
    // Host interrupt raised by the DSP, cleared by the host
    @(posedge clk_sys);
    dsp_host_irq_out_set <= 1'b1;
    @(posedge clk_sys);
    dsp_host_irq_out_set <= 1'b0;
    idle(4);
    `CHK(host_irq_out, 1'b0)
    rdh(2'h0, rd);
    `CHK(rd[`HP_BIT_HOST_IRQ_OUT], 1'b1)
    `CHK(rd[`HP_BIT_READY], 1'b1)
    wr(2'h0, 16'h0006);
    idle(4);
    `CHK(host_irq_out, 1'b1)
    `CHK(dspint_cnt, 1)
    // Fetch loads the data register from the current address
    wr(2'h0, 16'h0010);
    `CHK(mem_wdata, 16'ha003)
    // Extended address bits written and read through the address register
    wr(2'h0, 16'h0020);
    wr(2'h2, 16'h0003);
    rdh(2'h2, rd);
    `CHK(rd, 16'h0003)
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h0000);
    // Strobes with select high are ignored and ready stays high
    b0 = busy_cnt;
    wr(2'h2, 16'h0009, 1'b0, 1'b1);
    `CHK(busy_cnt, b0)
    rdh(2'h2, rd);
    `CHK(rd, 16'h0006)
    // Emulation off floats ready, interrupt and data
    @(posedge clk_sys);
    emulation_off_n <= 1'b0;
    idle(4);
    `CHK({host_ready_oe, host_irq_oe}, 2'h0)
    oe0 = oe_cnt;
    rdh(2'h0, rd);
    `CHK(oe_cnt, oe0)
    @(posedge clk_sys);
    emulation_off_n <= 1'b1;
    // Port reset, enable low and byte width each leave the port deaf
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      port_reset_in   <= (k == 0);
      port_enable_in  <= (k != 1);
      width_select_in <= (k != 2);
      repeat (4) @(posedge clk_sys);
      oe0 = oe_cnt;
      wr(2'h2, 16'h000a);
      rdh(2'h2, rd);
      `CHK(oe_cnt, oe0)
      @(posedge clk_sys);
      {port_reset_in, port_enable_in, width_select_in} <= 3'h3;
      repeat (4) @(posedge clk_sys);
      rdh(2'h2, rd);
      `CHK(rd, 16'h0006)
    end
    // Non-multiplexed access goes to the pin address without increment
    @(posedge clk_sys);
    mux_mode_select <= 1'b1;
    host_addr_in    <= 18'h00005;
    repeat (4) @(posedge clk_sys);
    wr(2'h1, 16'h1234);
    `CHK(mem[5], 16'h1234)
    @(posedge clk_sys);
    mux_mode_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdh(2'h2, rd);
    `CHK(rd, 16'h0005)
    stop_test();
  end
endmodule
